// file: verilog/adc_host_port.sv
// Host parallel port: register writes, FIFO readout, block-ready pulse
// Function
// - block_ready_n tells host a block of trigger-level size is waiting.
// - Allowed trigger levels depend on channel count; one channel: 1,4,8,14.
// - Block readiness is a one-cycle low pulse, not a level.
// - Read strobe is select_low_n low, select_high high and read_n low together.
// - Two 10-bit control registers program the operating mode.
// - D0-D9 carry value, D10/D11 address; D11 high codes are reserved.
// - Register 0 fields: vref, mode, power-down, channel, diff, scan, test.
// - Register 1 fields: reset, clear, level, type, polarity, rw, format, offset, readback.
// - Reference select resets to zero; zero internal, one external.
// - Continuous mode: one result enters FIFO each conversion clock falling edge.
// - Single mode: clock falling edge holds all selected inputs, starts sequence.
// - Single mode: block ready only once written count reaches trigger level.
// - Power-down bit resets to zero; one powers the converter down.
// - Register writes and FIFO reads still work while powered down.
// - Channel select bits reset to zero and pick the converted input; here they only set the channel count in autoscan.
// - Differential count bits reset to D6 zero, D5 one.
// - Scan bit resets to zero and switches autoscan.
// - Test bits reset to zero and substitute internal test voltages.
// - Test codes: 00 normal, 01 positive ref, 10 midpoint, 11 negative ref.
// - Autoscan writes channels in fixed order, first word is first channel.
`timescale 1ns/10ps
module adc_host_port
#(
  parameter int DEPTH = adc_port_pkg::FIFO_DEPTH,
  parameter int PW    = adc_port_pkg::PTR_W
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Host bus
  input  wire logic        select_low_n,
  input  wire logic        select_high,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic [11:0] data_in,
  output logic      [11:0] data_out,
  output logic             data_oe_n,
  // Conversion clock or single start
  input  wire logic        conversion_clock_in,
  // Converter result per channel slot
  input  wire logic [11:0] sample_in,
  // Analog front-end controls
  output logic             vref_external,
  output logic             power_down,
  output logic             hold_strobe,
  output logic [1:0]       scan_channel,
  output logic [1:0]       selftest_sel,
  // Block-ready pulse to host
  output logic             block_ready_n
);
  // Pointers wrap by overflow, so the depth must be a power of two
  if (DEPTH != (1 << PW) || DEPTH < adc_port_pkg::FIFO_DEPTH)
  begin : g_depth_check
    $error("adc_host_port: DEPTH must be 2**PW and at least 16");
  end

  typedef struct packed {
    logic [9:0]    mode_and_channel_config;
    logic [9:0]    fifo_and_format_config;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [4:0]    pending;
    logic [1:0]    slot;
    logic [1:0]    seq_left;
    logic          read_prev;
    logic          write_prev;
    logic [11:0]   data_out;
    logic          data_oe_n;
    logic          hold_strobe;
    logic          block_ready_n;
  } port_state_t;

  port_state_t st;
  port_state_t next_st;
  logic [11:0] mem [DEPTH];
  logic        conv_fell;
  logic        read_active;
  logic        write_active;
  logic        read_take;
  logic        write_take;
  logic        push;
  logic [11:0] push_word;
  logic [4:0]  level;
  logic [1:0]  nchan_m1;
  logic [1:0]  sel_code;

  edge_detect u_conv_edge
  (
    .clk   (clk),
    .reset (reset),
    .level (conversion_clock_in),
    .fell  (conv_fell)
  );

  // Qualified strobes; taken on the first cycle of each assertion
  assign read_active  = ~select_low_n & select_high & ~read_n;
  assign write_active = ~select_low_n & select_high & ~write_n;
  assign read_take    = read_active & ~st.read_prev;
  assign write_take   = write_active & ~st.write_prev;
  assign sel_code     = data_in[adc_port_pkg::ADDR_HI:adc_port_pkg::ADDR_LO];

  // Channel count minus one from the scan bit and the channel field
  always_comb
  begin
    nchan_m1 = 2'h0;
    if (st.mode_and_channel_config[adc_port_pkg::B_SCAN])
      nchan_m1 = st.mode_and_channel_config[adc_port_pkg::B_DIFF_LO]
               ? st.mode_and_channel_config[adc_port_pkg::B_CHAN_LO +: 2]
               : (st.mode_and_channel_config[adc_port_pkg::B_DIFF_LO + 1]
                  ? st.mode_and_channel_config[adc_port_pkg::B_CHAN_LO +: 2]
                  : st.mode_and_channel_config[adc_port_pkg::B_CHAN_LO +: 2]);
  end

  // Level: single channel uses the fixed table; more channels use multiples of the count
  always_comb
  begin
    level = adc_port_pkg::LEVEL_0;
    if (nchan_m1 == 2'h0)
    begin
      case (st.fifo_and_format_config[adc_port_pkg::B_LEVEL_LO +: 2])
        2'h0:    level = adc_port_pkg::LEVEL_0;
        2'h1:    level = adc_port_pkg::LEVEL_1;
        2'h2:    level = adc_port_pkg::LEVEL_2;
        default: level = adc_port_pkg::LEVEL_3;
      endcase
    end
    else
    begin
      level = 5'({3'h0, nchan_m1} + 5'h01);
      if (st.fifo_and_format_config[adc_port_pkg::B_LEVEL_LO])
        level = 5'(level << 1);
    end
  end

  // Converted word, replaced by a test voltage when a test code is set
  always_comb
  begin
    case (st.mode_and_channel_config[adc_port_pkg::B_TEST_LO +: 2])
      adc_port_pkg::TEST_REFP: push_word = adc_port_pkg::CODE_REFP;
      adc_port_pkg::TEST_MID:  push_word = adc_port_pkg::CODE_MID;
      adc_port_pkg::TEST_REFM: push_word = adc_port_pkg::CODE_REFM;
      default:                 push_word = sample_in;
    endcase
  end

  // One slot per cycle; no conversion while powered down
  assign push = ~st.mode_and_channel_config[adc_port_pkg::B_POWER_DOWN] &
                (st.mode_and_channel_config[adc_port_pkg::B_SINGLE]
                 ? (st.seq_left != 2'h0 || conv_fell)
                 : conv_fell);

  always_comb
  begin
    next_st               = st;
    next_st.read_prev     = read_active;
    next_st.write_prev    = write_active;
    next_st.hold_strobe   = 1'b0;
    next_st.block_ready_n = 1'b1;
    next_st.data_oe_n     = ~read_active;

    // Overflow overwrites the oldest word; the host must keep up with block_ready_n
    if (push)
    begin
      if (st.seq_left == 2'h0)
      begin
        next_st.hold_strobe = st.mode_and_channel_config[adc_port_pkg::B_SINGLE];
        next_st.seq_left    = st.mode_and_channel_config[adc_port_pkg::B_SINGLE] ? nchan_m1 : 2'h0;
      end
      else
        next_st.seq_left = 2'(st.seq_left - 2'h1);
      next_st.wr_ptr = PW'(st.wr_ptr + 1'b1);
      next_st.slot   = (st.slot == nchan_m1) ? 2'h0 : 2'(st.slot + 2'h1);
      if (5'(st.pending + 5'h01) >= level)
      begin
        next_st.pending       = 5'h00;
        next_st.block_ready_n = 1'b0;
      end
      else
        next_st.pending = 5'(st.pending + 5'h01);
    end

    // No empty check: reading an empty queue returns stale data and still advances
    if (read_take)
    begin
      next_st.data_out = mem[st.rd_ptr];
      next_st.rd_ptr   = PW'(st.rd_ptr + 1'b1);
    end

    // Queue clear or soft reset restarts pointers and scan order
    if (st.fifo_and_format_config[adc_port_pkg::B_QUEUE_CLEAR] |
        st.fifo_and_format_config[adc_port_pkg::B_SOFT_RESET])
    begin
      next_st.wr_ptr  = '0;
      next_st.rd_ptr  = '0;
      next_st.pending = 5'h00;
      next_st.slot    = 2'h0;
      next_st.seq_left = 2'h0;
      next_st.fifo_and_format_config[adc_port_pkg::B_QUEUE_CLEAR] = 1'b0;
      next_st.fifo_and_format_config[adc_port_pkg::B_SOFT_RESET]  = 1'b0;
      if (st.fifo_and_format_config[adc_port_pkg::B_SOFT_RESET])
        next_st.mode_and_channel_config = adc_port_pkg::MODE_CFG_RESET;
    end

    // Host write comes last so a new write wins over the self-clear
    // Register writes stay open in power-down
    if (write_take)
    begin
      case (sel_code)
        adc_port_pkg::SEL_MODE_CFG: next_st.mode_and_channel_config = data_in[9:0];
        adc_port_pkg::SEL_FIFO_CFG: next_st.fifo_and_format_config  = data_in[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st.mode_and_channel_config <= adc_port_pkg::MODE_CFG_RESET;
      st.fifo_and_format_config  <= adc_port_pkg::FIFO_CFG_RESET;
      st.wr_ptr        <= '0;
      st.rd_ptr        <= '0;
      st.pending       <= 5'h00;
      st.slot          <= 2'h0;
      st.seq_left      <= 2'h0;
      st.read_prev     <= 1'b0;
      st.write_prev    <= 1'b0;
      st.data_out      <= 12'h000;
      st.data_oe_n     <= 1'b1;
      st.hold_strobe   <= 1'b0;
      st.block_ready_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Storage has no reset; the pointers define what is valid
  always_ff @(posedge clk)
  begin
    if (push)
      mem[st.wr_ptr] <= push_word;
  end

  // Outputs from flip-flops; field outputs straight from the registers
  assign data_out      = st.data_out;
  assign data_oe_n     = st.data_oe_n;
  assign block_ready_n = st.block_ready_n;
  assign hold_strobe   = st.hold_strobe;
  assign scan_channel  = st.slot;
  assign vref_external = st.mode_and_channel_config[adc_port_pkg::B_VREF];
  assign power_down    = st.mode_and_channel_config[adc_port_pkg::B_POWER_DOWN];
  assign selftest_sel  = st.mode_and_channel_config[adc_port_pkg::B_TEST_LO +: 2];

  chk_ready_one_cycle: assert property (@(posedge clk) disable iff (reset)
    !block_ready_n |=> block_ready_n) else $error("block ready held low");
  chk_write_mode_reg: assert property (@(posedge clk) disable iff (reset)
    (write_take && sel_code == 2'h0 && !st.fifo_and_format_config[0])
    |=> st.mode_and_channel_config == $past(data_in[9:0])) else $error("mode write lost");
  chk_reserved_ignored: assert property (@(posedge clk) disable iff (reset)
    (write_take && data_in[11] && st.fifo_and_format_config[1:0] == 2'h0) |=>
    $stable(st.mode_and_channel_config) && $stable(st.fifo_and_format_config))
    else $error("reserved write changed registers");
  chk_read_advance: assert property (@(posedge clk) disable iff (reset)
    (read_take && st.fifo_and_format_config[1:0] == 2'h0) |=> st.rd_ptr == $past(st.rd_ptr) + 1'b1)
    else $error("read pointer not advanced");
  chk_read_qualify: assert property (@(posedge clk) disable iff (reset)
    (select_low_n || !select_high || read_n) |=> data_oe_n) else $error("drive without strobe");
  chk_no_push_powered: assert property (@(posedge clk) disable iff (reset)
    (power_down && st.fifo_and_format_config[1:0] == 2'h0) |=> $stable(st.wr_ptr) && block_ready_n)
    else $error("conversion in power down");
  chk_ready_level: assert property (@(posedge clk) disable iff (reset)
    (push && 5'(st.pending + 5'h01) < level && st.fifo_and_format_config[1:0] == 2'h0)
    |=> block_ready_n) else $error("early block ready");
  chk_single_hold: assert property (@(posedge clk) disable iff (reset)
    (push && st.seq_left == 2'h0 && st.mode_and_channel_config[1] &&
     st.fifo_and_format_config[1:0] == 2'h0) |=> hold_strobe) else $error("no hold strobe");
  chk_slot_wrap: assert property (@(posedge clk) disable iff (reset)
    (push && st.slot == nchan_m1 && st.fifo_and_format_config[1:0] == 2'h0
     && !write_take) |=> scan_channel == 2'h0) else $error("scan order broken");
  // Clear bits are left out where they restart the queue on purpose
  chk_soft_reset_mode: assert property (@(posedge clk) disable iff (reset)
    (st.fifo_and_format_config[adc_port_pkg::B_SOFT_RESET] && !write_take)
    |=> st.mode_and_channel_config == adc_port_pkg::MODE_CFG_RESET) else $error("soft reset kept mode");
  chk_clear_self: assert property (@(posedge clk) disable iff (reset)
    (st.fifo_and_format_config[1:0] != 2'h0 && !write_take)
    |=> st.fifo_and_format_config[1:0] == 2'h0 && st.wr_ptr == st.rd_ptr) else $error("queue clear not applied");
  chk_oe_on_read: assert property (@(posedge clk) disable iff (reset)
    read_take |=> !data_oe_n) else $error("no drive on read");
  chk_hold_single_only: assert property (@(posedge clk) disable iff (reset)
    !st.mode_and_channel_config[adc_port_pkg::B_SINGLE] |=> !hold_strobe) else $error("hold in continuous mode");
  cov_block_ready: cover property (@(posedge clk) disable iff (reset) !block_ready_n);
  cov_pd_read: cover property (@(posedge clk) disable iff (reset) read_take && power_down);
  cov_single: cover property (@(posedge clk) disable iff (reset) hold_strobe);
  cov_reserved_write: cover property (@(posedge clk) disable iff (reset) write_take && data_in[adc_port_pkg::ADDR_HI]);
  cov_soft_reset: cover property (@(posedge clk) disable iff (reset) st.fifo_and_format_config[adc_port_pkg::B_SOFT_RESET]);
endmodule // adc_host_port

// file: verilog/adc_port_pkg.sv
// Package: constants for the converter host port
package adc_port_pkg;
  localparam int DATA_W        = 12;
  localparam int REG_W         = 10;
  localparam int FIFO_DEPTH    = 16;
  localparam int PTR_W         = 4;
  localparam int ADDR_LO       = 10;
  localparam int ADDR_HI       = 11;
  // Register select codes on the two upper data lines
  localparam logic [1:0] SEL_MODE_CFG = 2'h0;
  localparam logic [1:0] SEL_FIFO_CFG = 2'h1;
  // Field positions of mode_and_channel_config
  localparam int B_VREF        = 0;
  localparam int B_SINGLE      = 1;
  localparam int B_POWER_DOWN  = 2;
  localparam int B_CHAN_LO     = 3;
  localparam int B_DIFF_LO     = 5;
  localparam int B_SCAN        = 7;
  localparam int B_TEST_LO     = 8;
  // Field positions of fifo_and_format_config
  localparam int B_SOFT_RESET  = 0;
  localparam int B_QUEUE_CLEAR = 1;
  localparam int B_LEVEL_LO    = 2;
  localparam int B_DATA_TYPE   = 4;
  localparam int B_DATA_POL    = 5;
  localparam int B_RW          = 6;
  localparam int B_NUM_FORMAT  = 7;
  localparam int B_OFFSET      = 8;
  localparam int B_READBACK    = 9;
  // Reset values
  localparam logic [9:0] MODE_CFG_RESET = 10'h020;
  localparam logic [9:0] FIFO_CFG_RESET = 10'h000;
  // Trigger levels for one channel, indexed by the level field
  localparam logic [4:0] LEVEL_0 = 5'h01;
  localparam logic [4:0] LEVEL_1 = 5'h04;
  localparam logic [4:0] LEVEL_2 = 5'h08;
  localparam logic [4:0] LEVEL_3 = 5'h0E;
  // Test field codes
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_REFP   = 2'h1;
  localparam logic [1:0] TEST_MID    = 2'h2;
  localparam logic [1:0] TEST_REFM   = 2'h3;
  // Test voltage codes (binary format)
  localparam logic [11:0] CODE_REFP = 12'hFFF;
  localparam logic [11:0] CODE_MID  = 12'h800;
  localparam logic [11:0] CODE_REFM = 12'h000;
endpackage

// file: verilog/edge_detect.sv
// Falling-edge detector for a synchronous pin input
`timescale 1ns/10ps
module edge_detect
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Sampled level and detected fall
  input  wire logic level,
  output logic      fell
);
  typedef struct packed {
    logic last;
  } edge_state_t;

  edge_state_t st;
  edge_state_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.last = level;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    // Starts low so a pin held low through reset cannot produce a false fall
    if (reset)
      st <= '{last: 1'b0};
    else
      st <= next_st;
  end

  assign fell = st.last & ~level;
endmodule // edge_detect

// file: dv/host_model.sv
// Host processor model that drives the converter's parallel bus
`timescale 1ns/10ps
module host_model
(
  // Clock
  input  wire logic        clk,
  // Bus driven by the host
  output logic             select_low_n,
  output logic             select_high,
  output logic             read_n,
  output logic             write_n,
  output logic [11:0]      data_in,
  // Bus driven by the device
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe_n
);
  initial
  begin
    select_low_n = 1'b1;
    select_high  = 1'b0;
    read_n       = 1'b1;
    write_n      = 1'b1;
    data_in      = 12'hA5A;
  end

  // Entered just after a rising edge; strobes drop for a cycle before returning
  task automatic wr(input logic [1:0] sel, input logic [9:0] val);
    select_low_n = 1'b0;
    select_high  = 1'b1;
    write_n      = 1'b0;
    data_in      = {sel, val};
    @(posedge clk) #1;
    select_low_n = 1'b1;
    select_high  = 1'b0;
    write_n      = 1'b1;
    // Released lines show the inverse so a stale value cannot look valid
    data_in      = ~{sel, val};
    @(posedge clk) #1;
  endtask

  // Taken at the first edge; the registered word is read just after it, where it stands
  task automatic rd(input logic cs_lo_n, input logic cs_hi, output logic [11:0] q, output logic oe_n);
    select_low_n = cs_lo_n;
    select_high  = cs_hi;
    read_n       = 1'b0;
    @(posedge clk) #1;
    q            = data_out;
    oe_n         = data_oe_n;
    select_low_n = 1'b1;
    select_high  = 1'b0;
    read_n       = 1'b1;
    @(posedge clk) #1;
  endtask
endmodule // host_model

// file: dv/testbench.sv
// Self-checking bench for the converter host port
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  typedef struct { logic [11:0] wr; logic vref; logic powered_down; logic [1:0] test; } row_t;
  logic        clk;
  logic        reset;
  logic        select_low_n;
  logic        select_high;
  logic        read_n;
  logic        write_n;
  logic [11:0] data_in;
  logic [11:0] data_out;
  logic        data_oe_n;
  logic        conversion_clock_in;
  logic [11:0] sample_in;
  logic        vref_external;
  logic        power_down;
  logic        hold_strobe;
  logic [1:0]  scan_channel;
  logic [1:0]  selftest_sel;
  logic        block_ready_n;
  logic [11:0] sample_base;
  logic [11:0] word;
  logic [11:0] exp_word;
  logic        oe;
  logic        prev_low;
  int          num_errors;
  int          check_count;
  int          pulses;
  int          holds;
  int          lvl;
  // Reserved select codes (D11 high) must leave the previous value in place
  row_t rows [8] = '{'{12'h001, 1'b1, 1'b0, 2'h0}, '{12'h004, 1'b0, 1'b1, 2'h0},
                     '{12'h100, 1'b0, 1'b0, 2'h1}, '{12'h200, 1'b0, 1'b0, 2'h2},
                     '{12'h300, 1'b0, 1'b0, 2'h3}, '{12'h801, 1'b0, 1'b0, 2'h3},
                     '{12'hC05, 1'b0, 1'b0, 2'h3}, '{12'h000, 1'b0, 1'b0, 2'h0}};

  assign sample_in = sample_base + {10'h000, scan_channel};

  adc_host_port dut_u (.clk(clk), .reset(reset), .select_low_n(select_low_n), .select_high(select_high),
    .read_n(read_n), .write_n(write_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .conversion_clock_in(conversion_clock_in), .sample_in(sample_in), .vref_external(vref_external),
    .power_down(power_down), .hold_strobe(hold_strobe), .scan_channel(scan_channel),
    .selftest_sel(selftest_sel), .block_ready_n(block_ready_n));

  host_model host_u (.clk(clk), .select_low_n(select_low_n), .select_high(select_high), .read_n(read_n),
    .write_n(write_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    if (block_ready_n === 1'b0)
    begin
      pulses++;
      `CHK("pulse width", 1'b0, prev_low)
    end
    if (hold_strobe === 1'b1)
      holds++;
    prev_low = (block_ready_n === 1'b0);
  end

  task automatic conv(input int n);
    repeat (n)
    begin
      conversion_clock_in = 1'b1;
      @(posedge clk) #1;
      conversion_clock_in = 1'b0;
      @(posedge clk) #1;
    end
    // Room for a single-mode sequence and the registered pulse
    repeat (4) @(posedge clk) #1;
  endtask

  task end_sim;
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    reset = 1'b1;
    conversion_clock_in = 1'b0;
    sample_base = 12'h000;
    prev_low = 1'b0;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    `CHK("vref reset", 1'b0, vref_external)
    `CHK("power down reset", 1'b0, power_down)
    `CHK("mode reset", 10'h020, dut_u.st.mode_and_channel_config)
    `CHK("test reset", 2'h0, selftest_sel)
    `CHK("scan reset", 2'h0, scan_channel)
    `CHK("ready idle", 1'b1, block_ready_n)
    `CHK("oe idle", 1'b1, data_oe_n)
    foreach (rows[i])
    begin
      host_u.wr(rows[i].wr[11:10], rows[i].wr[9:0]);
      `CHK("vref", rows[i].vref, vref_external)
      `CHK("power down", rows[i].powered_down, power_down)
      `CHK("test sel", rows[i].test, selftest_sel)
    end
    // Block sizes for one channel; queue clear keeps each block aligned
    for (int k = 0; k < 4; k++)
    begin
      lvl = (k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14;
      host_u.wr(2'h1, {6'h00, 2'(k), 2'h2});
      pulses = 0;
      for (int s = 0; s < lvl; s++)
      begin
        sample_base = 12'(12'h300 + k * 16 + s);
        conv(1);
        `CHK("block pulses", (s == lvl - 1) ? 1 : 0, pulses)
        `CHK("ready back high", 1'b1, block_ready_n)
      end
      for (int s = 0; s < lvl; s++)
      begin
        host_u.rd(1'b0, 1'b1, word, oe);
        `CHK("fifo word", 12'(12'h300 + k * 16 + s), word)
        `CHK("oe during read", 1'b0, oe)
      end
    end
    host_u.wr(2'h1, 10'h002);
    for (int t = 1; t < 4; t++)
    begin
      host_u.wr(2'h0, {2'(t), 8'h00});
      conv(1);
      host_u.rd(1'b0, 1'b1, word, oe);
      exp_word = (t == 1) ? adc_port_pkg::CODE_REFP : (t == 2) ? adc_port_pkg::CODE_MID : adc_port_pkg::CODE_REFM;
      `CHK("test code", exp_word, word)
    end
    // Partial strobes must neither drive the bus nor move the read pointer
    host_u.wr(2'h0, 10'h000);
    sample_base = 12'h5A5;
    conv(1);
    host_u.rd(1'b1, 1'b1, word, oe);
    `CHK("oe cs low off", 1'b1, oe)
    host_u.rd(1'b0, 1'b0, word, oe);
    `CHK("oe cs high off", 1'b1, oe)
    host_u.rd(1'b0, 1'b1, word, oe);
    `CHK("qualified read", 12'h5A5, word)
    sample_base = 12'h3C3;
    conv(1);
    host_u.wr(2'h0, 10'h004);
    pulses = 0;
    sample_base = 12'h111;
    conv(2);
    `CHK("no push in powerdown", 0, pulses)
    host_u.rd(1'b0, 1'b1, word, oe);
    `CHK("read in powerdown", 12'h3C3, word)
    // Single start, two-slot autoscan, block of two
    host_u.wr(2'h0, 10'h08A);
    `CHK("powerdown cleared", 1'b0, power_down)
    pulses = 0;
    holds = 0;
    sample_base = 12'h700;
    conv(1);
    repeat (4) @(posedge clk) #1;
    `CHK("hold pulses", 1, holds)
    `CHK("single block", 1, pulses)
    for (int s = 0; s < 2; s++)
    begin
      host_u.rd(1'b0, 1'b1, word, oe);
      `CHK("scan order", 12'(12'h700 + s), word)
    end
    host_u.wr(2'h0, 10'h001);
    `CHK("vref set", 1'b1, vref_external)
    host_u.wr(2'h1, 10'h001);
    `CHK("soft reset mode", 10'h020, dut_u.st.mode_and_channel_config)
    host_u.wr(2'h0, 10'h001);
    reset = 1'b1;
    @(posedge clk) #1;
    reset = 1'b0;
    `CHK("vref second reset", 1'b0, vref_external)
    `CHK("mode second reset", 10'h020, dut_u.st.mode_and_channel_config)
    end_sim();
  end
endmodule // testbench
